// [include/pmr_defs.svh]
// Purpose: Timing counts and fixed codes for the MAC receive port.
// Assumes: sys_clk at 200 MHz.
// Notes:   Half periods are sys_clk cycles between toggles of a generated clock.
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

`define PMR_SYS_CLK_HZ 200000000
`define PMR_MII100_CLK_HZ 25000000
`define PMR_MII10_CLK_HZ 2500000
`define PMR_SERIAL_CLK_HZ 10000000
`define PMR_RMII_CLK_HZ 50000000
`define PMR_HALF_MII100 (`PMR_SYS_CLK_HZ / (2 * `PMR_MII100_CLK_HZ))
`define PMR_HALF_MII10 (`PMR_SYS_CLK_HZ / (2 * `PMR_MII10_CLK_HZ))
`define PMR_HALF_SERIAL (`PMR_SYS_CLK_HZ / (2 * `PMR_SERIAL_CLK_HZ))
`define PMR_HALF_RMII (`PMR_SYS_CLK_HZ / (2 * `PMR_RMII_CLK_HZ))
`define PMR_SQE_NS 1000
`define PMR_SQE_CYCLES ((`PMR_SQE_NS * (`PMR_SYS_CLK_HZ / 1000000)) / 1000)
`define PMR_RMII_ERR_DIBIT 2'h1

`endif

// [include/pmr_pkg.sv]
// Purpose: Types shared by the MAC receive port and its bench.
// Assumes: Counts live in pmr_defs.svh.
// Notes:   Mode codes match the receive interface variants.
package pmr_pkg;

    typedef enum logic [1:0] {
        PMR_MODE_MII = 2'h0,
        PMR_MODE_RMII = 2'h1,
        PMR_MODE_SERIAL = 2'h2
    } pmr_mode_t;

    // Receive symbols from the physical coding layer, same clock domain
    typedef struct packed {
        logic [3:0] data;
        logic dataValid;
        logic carrier;
        logic invalidSymbol;
        logic falseCarrier;
        logic txActive;
    } pmr_core_t;

    // MAC-facing receive pins; carrierSense is the combined output in RMII
    typedef struct packed {
        logic rxClk;
        logic [3:0] rxData;
        logic rxDataValid;
        logic rxError;
        logic carrierSense;
        logic collision;
    } pmr_pins_t;

endpackage

// [verilog/pmr_receive_port.sv]
// Purpose: Receive side of one MAC data port with MII, RMII and serial modes.
// Assumes: Core inputs are on sys_clk; reference_clock_in is asynchronous.
// Notes:   Generated clocks are divided from sys_clk and leave flip-flops.
`timescale 1ns/100ps
`default_nettype none
`include "pmr_defs.svh"

module pmr_receive_port #(
    parameter int DIV_W = 6
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire pmr_pkg::pmr_mode_t mode,
    input wire logic speed100,
    input wire logic fullDuplex,
    input wire logic heartbeatEnable,
    input wire logic macClockDisableStrap,
    input wire logic reference_clock_in,
    input wire pmr_pkg::pmr_core_t core,
    output pmr_pkg::pmr_pins_t pins,
    output logic mac_clock_out
);

    initial begin
        if (DIV_W < 6 || `PMR_HALF_MII10 >= (1 << DIV_W)) begin
            $error("pmr_receive_port: DIV_W too small for the 2.5 MHz divider");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference clock sampling and strap capture

    logic refSync1;
    logic refSync2;
    logic refSync3;
    logic refLevel;
    logic strapTaken;
    logic macClockDisabled;

    // A change counts once the second and third stages agree
    wire refAgree = (refSync2 == refSync3);
    wire refRise = refAgree && refSync3 && !refLevel;

    always_ff @(posedge sys_clk) begin
        refSync1 <= reference_clock_in;
        refSync2 <= refSync1;
        refSync3 <= refSync2;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            // Start from the pin's present level so reset release gives no false edge
            refLevel <= refSync3;
        end else if (refAgree) begin
            refLevel <= refSync3;
        end
    end

    // Strap is caught on the first clock after reset release
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            strapTaken <= 1'b0;
            macClockDisabled <= 1'b1;
        end else if (!strapTaken) begin
            strapTaken <= 1'b1;
            macClockDisabled <= macClockDisableStrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock dividers

    wire isMii = (mode == pmr_pkg::PMR_MODE_MII);
    wire isRmii = (mode == pmr_pkg::PMR_MODE_RMII);
    wire isSerial = (mode == pmr_pkg::PMR_MODE_SERIAL);

    localparam logic [DIV_W-1:0] HALF_MII100 = DIV_W'(`PMR_HALF_MII100);
    localparam logic [DIV_W-1:0] HALF_MII10 = DIV_W'(`PMR_HALF_MII10);
    localparam logic [DIV_W-1:0] HALF_SERIAL = DIV_W'(`PMR_HALF_SERIAL);
    localparam logic [DIV_W-1:0] HALF_RMII = DIV_W'(`PMR_HALF_RMII);
    localparam logic [7:0] SQE_CYCLES = 8'(`PMR_SQE_CYCLES);

    logic [DIV_W-1:0] rxDivCount;
    logic [DIV_W-1:0] macDivCount;
    logic rxClkState;
    logic macClkState;

    wire [DIV_W-1:0] rxHalf = isSerial ? HALF_SERIAL :
        (speed100 ? HALF_MII100 : HALF_MII10);
    wire [DIV_W-1:0] macHalf = isRmii ? HALF_RMII : HALF_MII100;
    wire rxToggle = !isRmii && (rxDivCount == rxHalf - DIV_W'(1));
    wire macToggle = (macDivCount == macHalf - DIV_W'(1));
    // Outputs change on the falling edge so the MAC samples mid-bit on rising
    wire rxFall = rxToggle && rxClkState;
    wire [DIV_W-1:0] next_rxDivCount = rxToggle ? '0 : rxDivCount + DIV_W'(1);
    wire [DIV_W-1:0] next_macDivCount = macToggle ? '0 : macDivCount + DIV_W'(1);

    always_ff @(posedge sys_clk) begin
        if (sys_rst || isRmii) begin
            rxDivCount <= '0;
            rxClkState <= 1'b0;
        end else begin
            rxDivCount <= next_rxDivCount;
            rxClkState <= rxToggle ? !rxClkState : rxClkState;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || macDivCount >= macHalf) begin
            macDivCount <= '0;
            macClkState <= 1'b0;
        end else begin
            macDivCount <= next_macDivCount;
            macClkState <= macToggle ? !macClkState : macClkState;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mac_clock_out <= 1'b0;
        end else begin
            mac_clock_out <= macClkState && !macClockDisabled;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Heartbeat (SQE test) after each 10 Mb/s half duplex transmission in MII and serial modes

    typedef enum logic [1:0] {
        PMR_SQE_IDLE = 2'h1,
        PMR_SQE_PULSE = 2'h2
    } pmr_sqe_t;

    pmr_sqe_t sqeState;
    pmr_sqe_t next_sqeState;
    logic [7:0] sqeCount;
    logic txActiveLast;

    wire txEnded = txActiveLast && !core.txActive;
    wire sqeAllowed = !speed100 && !fullDuplex && heartbeatEnable && !isRmii;
    wire sqeDone = (sqeCount == SQE_CYCLES - 8'h01);

    always_comb begin
        next_sqeState = sqeState;
        case (sqeState)
            PMR_SQE_IDLE: begin
                if (txEnded && sqeAllowed) begin
                    next_sqeState = PMR_SQE_PULSE;
                end
            end
            PMR_SQE_PULSE: begin
                if (sqeDone || fullDuplex) begin
                    next_sqeState = PMR_SQE_IDLE;
                end
            end
            default: next_sqeState = PMR_SQE_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sqeState <= PMR_SQE_IDLE;
            sqeCount <= 8'h00;
            txActiveLast <= 1'b0;
        end else begin
            sqeState <= next_sqeState;
            sqeCount <= (sqeState == PMR_SQE_PULSE) ? sqeCount + 8'h01 : 8'h00;
            txActiveLast <= core.txActive;
        end
    end

    // Collision is a plain level; it is not tied to the receive clock
    wire sqeActive = (sqeState == PMR_SQE_PULSE);
    wire next_collision = !isRmii && !fullDuplex &&
        ((core.txActive && core.carrier) || sqeActive);

    ////////////////////////////////////////////////////////////////////////////
    // Receive data path

    logic dibitPhase;
    logic [1:0] upperDibit;
    logic upperError;

    // Dibits go out low pair first; the upper pair is held for the next edge
    wire rmiiErrNow = (speed100 && core.invalidSymbol && core.dataValid)
        || core.falseCarrier;
    wire rmiiErr = dibitPhase ? upperError : rmiiErrNow;
    wire [1:0] rmiiRaw = dibitPhase ? upperDibit : core.data[1:0];
    // Replacing data on error makes the frame fail its check at the MAC
    wire [1:0] rmiiData = rmiiErr ? `PMR_RMII_ERR_DIBIT : rmiiRaw;
    wire rmiiCrsDv = core.carrier || core.dataValid;

    wire miiErr = speed100 && core.invalidSymbol && core.dataValid;

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !isRmii) begin
            dibitPhase <= 1'b0;
            upperDibit <= 2'h0;
            upperError <= 1'b0;
        end else if (refRise) begin
            dibitPhase <= core.dataValid ? !dibitPhase : 1'b0;
            upperDibit <= core.data[3:2];
            upperError <= rmiiErrNow;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pins <= '0;
        end else begin
            pins.rxClk <= rxClkState;
            pins.collision <= next_collision;
            if (isRmii && refRise) begin
                pins.rxData <= {2'h0, rmiiData};
                pins.rxDataValid <= core.dataValid;
                pins.rxError <= rmiiErr;
                pins.carrierSense <= rmiiCrsDv;
            end else if (isMii && rxFall) begin
                pins.rxData <= core.dataValid ? core.data : 4'h0;
                pins.rxDataValid <= core.dataValid;
                pins.rxError <= miiErr;
                pins.carrierSense <= core.carrier;
            end else if (isSerial && rxFall) begin
                pins.rxData <= {3'h0, core.data[0] && core.carrier};
                pins.rxDataValid <= 1'b0;
                pins.rxError <= 1'b0;
                pins.carrierSense <= core.carrier;
            end
        end
    end

endmodule
`default_nettype wire

// [sim/pmr_receive_port_sva.sv]
// Purpose: Port checks for the MAC receive port.
// Assumes: Mode, speed, duplex and strap change only under reset.
// Notes: Bound into every instance.
`timescale 1ns/100ps
`default_nettype none
`include "pmr_defs.svh"
module pmr_receive_port_sva (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire pmr_pkg::pmr_mode_t mode,
    input wire logic speed100,
    input wire logic fullDuplex,
    input wire logic heartbeatEnable,
    input wire pmr_pkg::pmr_core_t core,
    input wire pmr_pkg::pmr_pins_t pins,
    input wire logic mac_clock_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [8:0] colRun;
    wire logic serial = (mode == pmr_pkg::PMR_MODE_SERIAL);
    wire logic rmii = (mode == pmr_pkg::PMR_MODE_RMII);
    wire logic sqeMode = !rmii && !speed100 && !fullDuplex && heartbeatEnable;
    // Length of the current collision run, read when it ends
    always_ff @(posedge sys_clk) begin
        colRun <= pins.collision ? colRun + 9'h1 : 9'h0;
    end
    sequence mcHigh4; mac_clock_out [*4]; endsequence
    sequence mcLow4; !mac_clock_out [*4]; endsequence
    sequence mcHigh2; mac_clock_out [*2]; endsequence
    sequence mcLow2; !mac_clock_out [*2]; endsequence
    AST_RESET_QUIET: assert property (disable iff (1'b0) sys_rst |=> pins == '0 && !mac_clock_out)
        else $error("outputs active during reset");
    AST_SERIAL_NO_ERR: assert property (serial |-> !pins.rxError)
        else $error("receive error in serial mode");
    AST_SERIAL_UPPER: assert property (serial |-> pins.rxData[3:1] == 3'h0)
        else $error("upper data lines used in serial mode");
    AST_FDX_NO_COL: assert property (fullDuplex ##1 fullDuplex |-> !pins.collision)
        else $error("collision in full duplex");
    AST_HDX_COL: assert property (!rmii && !fullDuplex && core.txActive && core.carrier |=> pins.collision)
        else $error("collision missing");
    AST_RMII_CORRUPT: assert property (rmii && pins.rxError |-> pins.rxData[1:0] == `PMR_RMII_ERR_DIBIT)
        else $error("errored data not corrupted");
    AST_MCLK_MII: assert property (!rmii && $rose(mac_clock_out) |-> mcHigh4 ##1 mcLow4)
        else $error("mac clock not 25 MHz");
    AST_MCLK_RMII: assert property (rmii && $rose(mac_clock_out) |-> mcHigh2 ##1 mcLow2)
        else $error("mac clock not 50 MHz");
    AST_SQE_LEN: assert property (sqeMode && !core.carrier && $fell(pins.collision) |-> colRun == `PMR_SQE_CYCLES)
        else $error("heartbeat pulse length wrong");
endmodule
bind pmr_receive_port pmr_receive_port_sva chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode(mode),
    .speed100(speed100), .fullDuplex(fullDuplex), .heartbeatEnable(heartbeatEnable), .core(core),
    .pins(pins), .mac_clock_out(mac_clock_out));
`default_nettype wire

// [sim/pmr_mac_model.sv]
// Purpose: Receiving MAC beside the port.
// Assumes: Pins are registered on sys_clk.
// Notes: Captures on the rising receive clock, away from data changes.
`timescale 1ns/100ps
`default_nettype none
module pmr_mac_model (
    input wire pmr_pkg::pmr_pins_t pins,
    input wire pmr_pkg::pmr_mode_t mode,
    input wire logic txEnable,
    output logic [3:0] lastNibble,
    output logic macCollision
);
    always @(posedge pins.rxClk) begin
        if (mode == pmr_pkg::PMR_MODE_SERIAL ? pins.carrierSense : pins.rxDataValid) begin
            lastNibble <= pins.rxData;
        end
    end
    // No collision pin in RMII, so carrier comes from the merged line
    assign macCollision = (mode == pmr_pkg::PMR_MODE_RMII) && pins.carrierSense && txEnable;
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Purpose: Self-checking bench for the MAC receive port.
// Assumes: Each configuration is set under reset.
// Notes: Holds are several receive clocks long so sampling phase does not matter.
`timescale 1ns/100ps
`default_nettype none
`include "pmr_defs.svh"
module testbench;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic refClk = 1'b0;
    pmr_pkg::pmr_mode_t mode = pmr_pkg::PMR_MODE_MII;
    logic speed100 = 1'b1;
    logic fullDuplex = 1'b0;
    logic heartbeatEnable = 1'b0;
    logic strap = 1'b0;
    logic macTx = 1'b0;
    pmr_pkg::pmr_core_t core = '0;
    pmr_pkg::pmr_pins_t pins;
    logic macClk;
    logic [3:0] lastNibble;
    logic macCollision;
    logic [31:0] seed = 32'h3f339a4d;
    int mismatches = 0;
    int checks = 0;
    int cnt;
    int cntClk;
    pmr_receive_port uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode(mode), .speed100(speed100),
        .fullDuplex(fullDuplex), .heartbeatEnable(heartbeatEnable), .macClockDisableStrap(strap),
        .reference_clock_in(refClk), .core(core), .pins(pins), .mac_clock_out(macClk));
    pmr_mac_model mac (.pins(pins), .mode(mode), .txEnable(macTx), .lastNibble(lastNibble),
        .macCollision(macCollision));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Odd offset keeps the reference unrelated in phase to sys_clk
    initial begin
        #7;
        forever #32 refClk = ~refClk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [3:0] expNib(input pmr_pkg::pmr_core_t c);
        return c.dataValid ? c.data : 4'h0;
    endfunction
    function automatic int sqeLen(input logic h, input logic f);
        return (h && !f) ? `PMR_SQE_CYCLES : 0;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic start(input pmr_pkg::pmr_mode_t m, input logic s, input logic f, input logic h,
        input logic d);
        @(negedge sys_clk);
        sys_rst = 1'b1;
        mode = m;
        speed100 = s;
        fullDuplex = f;
        heartbeatEnable = h;
        strap = d;
        core = '0;
        macTx = 1'b0;
        ticks(3);
        chk(pins, 9'h0, "reset pins");
        sys_rst = 1'b0;
        ticks(2);
    endtask
    task automatic countHigh(input int n);
        cnt = 0;
        cntClk = 0;
        repeat (n) begin
            @(negedge sys_clk);
            cnt += pins.collision;
            cntClk += macClk;
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        start(pmr_pkg::PMR_MODE_MII, 1'b1, 1'b0, 1'b0, 1'b0);
        core.carrier = 1'b1;
        repeat (6) begin
            core.data = 4'(rnd());
            core.dataValid = seed[7];
            ticks(24);
            chk(pins.rxData, expNib(core), "rx nibble");
            chk(pins.rxDataValid, core.dataValid, "rx valid");
            chk(pins.carrierSense, 1'b1, "carrier");
        end
        core.dataValid = 1'b1;
        ticks(24);
        chk(lastNibble, core.data, "mac nibble");
        core.txActive = 1'b1;
        countHigh(40);
        chk(cnt, 40, "collision");
        chk(cntClk, 20, "mac clock mii");
        for (int i = 0; i < 3; i++) begin
            start(pmr_pkg::PMR_MODE_MII, 1'b0, i == 1, i != 2, 1'b0);
            core.txActive = 1'b1;
            ticks(100);
            core.txActive = 1'b0;
            countHigh(400);
            chk(cnt, sqeLen(i != 2, i == 1), "heartbeat length");
        end
        start(pmr_pkg::PMR_MODE_SERIAL, 1'b0, 1'b0, 1'b0, 1'b0);
        core.carrier = 1'b1;
        core.invalidSymbol = 1'b1;
        repeat (4) begin
            core.data = 4'(rnd());
            ticks(60);
            chk(pins.rxData, {3'h0, core.data[0]}, "serial bit");
            chk(lastNibble, {3'h0, core.data[0]}, "mac serial bit");
            chk(pins.rxError, 1'b0, "serial error");
        end
        start(pmr_pkg::PMR_MODE_RMII, 1'b1, 1'b0, 1'b0, 1'b0);
        core.carrier = 1'b1;
        core.dataValid = 1'b1;
        core.txActive = 1'b1;
        macTx = 1'b1;
        countHigh(40);
        chk(cnt, 0, "rmii collision");
        chk(cntClk, 20, "mac clock rmii");
        chk(macCollision, 1'b1, "mac collision");
        for (int i = 0; i < 2; i++) begin
            core.invalidSymbol = (i == 0);
            core.falseCarrier = (i == 1);
            ticks(40);
            chk(pins.rxError, 1'b1, "rmii error");
            chk(pins.rxData[1:0], 2'h1, "rmii corrupt");
        end
        start(pmr_pkg::PMR_MODE_RMII, 1'b1, 1'b0, 1'b0, 1'b1);
        countHigh(40);
        chk(cntClk, 0, "mac clock disabled");
        end_of_test();
    end
endmodule
`default_nettype wire
